// >>> xbus_consts.svh
// Purpose: Constants for the peripheral bus decode and buffer control block
// Assumes: ISA system clock at 50 MHz
// Notes:   Addresses are I/O port numbers on SA[15:0]
`ifndef XBUS_CONSTS_SVH
`define XBUS_CONSTS_SVH
`define PORT_CLK_INDEX   16'h0070
`define PORT_CLK_DATA    16'h0071
`define PORT_KBC_DATA    16'h0060
`define PORT_KBC_CMD     16'h0064
`define PORT_MC_DATA     16'h0062
`define PORT_MC_CMD      16'h0066
`define ALE_PERIODS      2
`define ALE_CNT_W        2
`define EN_FW_BIT        0
`define EN_KBC_BIT       1
`define EN_CLK_BIT       2
`define EN_MC_BIT        3
`define EN_PCS0_BIT      4
`define EN_PCS1_BIT      5
`endif

// >>> xbus_pkg.sv
// Purpose: Types for the peripheral bus decode and buffer control block
// Assumes: Used with xbus_consts.svh
// Notes:   None
`default_nettype none
package xbus_pkg;
    typedef struct packed {
        logic ior_n;
        logic iow_n;
        logic memr_n;
        logic memw_n;
    } isa_cmd_s;
    typedef struct packed {
        logic use_gpo_ale;
        logic use_gpo_ccs;
        logic use_gpo_dir;
        logic use_gpo_oe;
    } gpo_sel_s;
    typedef struct packed {
        logic ale;
        logic ccs;
        logic dir;
        logic oe;
    } gpo_lvl_s;
    typedef enum logic [1:0] {DIR_IDLE, DIR_IO, DIR_MEM, DIR_DMA} dir_state_e;
endpackage
`default_nettype wire

// >>> xbus_ctrl.sv
// Purpose: Peripheral bus decode, clock chip strobes and transceiver control
// Assumes: ISA command pins are asynchronous and pass two flip-flops first
// Notes:   Decoded selects are registered; one clock of latency after sync
`include "xbus_consts.svh"
`default_nettype none
module xbus_ctrl
    import xbus_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // ISA bus pins
    input  wire isa_cmd_s    cmd_n_in,
    input  wire logic [15:0] sa_in,
    input  wire logic        isa_master_in,
    input  wire logic        dma_read_ack_n_in,
    input  wire logic        kbc_cpu_reset_req_n_in,
    // Decodes from neighbouring logic
    input  wire logic        fw_decode_in,
    input  wire logic        apic_decode_in,
    input  wire logic        prog_sel0_n_in,
    input  wire logic        prog_sel1_n_in,
    // Configuration
    input  wire logic [5:0]  decode_en_in,
    input  wire gpo_sel_s    gpo_sel_in,
    input  wire gpo_lvl_s    gpo_lvl_in,
    // Outputs
    output var  logic        cpu_init_out,
    output var  logic        clock_addr_latch_strobe_out,
    output var  logic        clock_chip_sel_n_out,
    output var  logic        keyboard_ctrl_sel_n_out,
    output var  logic        microcontroller_sel_n_out,
    output var  logic        xcvr_direction_n_out,
    output var  logic        xcvr_output_enable_n_out
);
    localparam int SYNC_W = 23;
    logic [SYNC_W-1:0] s1_q;
    logic [SYNC_W-1:0] s2_q;
    logic [SYNC_W-1:0] raw;
    assign raw = {cmd_n_in, sa_in, isa_master_in, dma_read_ack_n_in, kbc_cpu_reset_req_n_in};
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s1_q <= '1;
            s2_q <= '1;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end
    isa_cmd_s    cmd_n;
    logic [15:0] sa;
    logic        isa_mst;
    logic        dack_n;
    logic        kbc_cpu_reset_req_n_n;
    assign {cmd_n, sa, isa_mst, dack_n, kbc_cpu_reset_req_n_n} = s2_q;

    logic [1:0] dec_s1_q;
    logic [1:0] dec_s2_q;
    logic [1:0] pcs_s1_q;
    logic [1:0] pcs_s2_q;
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            dec_s1_q <= 2'h0;
            dec_s2_q <= 2'h0;
            pcs_s1_q <= 2'h3;
            pcs_s2_q <= 2'h3;
        end else begin
            dec_s1_q <= {fw_decode_in, apic_decode_in};
            dec_s2_q <= dec_s1_q;
            pcs_s1_q <= {prog_sel1_n_in, prog_sel0_n_in};
            pcs_s2_q <= pcs_s1_q;
        end
    end
    logic fw_dec;
    logic apic_dec;
    assign {fw_dec, apic_dec} = dec_s2_q;

    logic iow_q;
    logic ior_q;
    logic memr_q;
    logic memw_q;
    logic dack_q;
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            iow_q  <= 1'b1;
            ior_q  <= 1'b1;
            memr_q <= 1'b1;
            memw_q <= 1'b1;
            dack_q <= 1'b1;
        end else begin
            iow_q  <= cmd_n.iow_n;
            ior_q  <= cmd_n.ior_n;
            memr_q <= cmd_n.memr_n;
            memw_q <= cmd_n.memw_n;
            dack_q <= dack_n;
        end
    end
    logic iow_fall;
    logic ior_fall;
    logic memr_fall;
    logic memw_fall;
    logic dack_fall;
    assign iow_fall  = iow_q & ~cmd_n.iow_n;
    assign ior_fall  = ior_q & ~cmd_n.ior_n;
    assign memr_fall = memr_q & ~cmd_n.memr_n;
    assign memw_fall = memw_q & ~cmd_n.memw_n;
    assign dack_fall = dack_q & ~dack_n;

    logic io_cyc;
    logic hit_clk_idx;
    logic hit_clk_dat;
    logic hit_kbc;
    logic hit_mc;
    logic pcs_act;
    assign io_cyc      = ~cmd_n.ior_n | ~cmd_n.iow_n;
    assign hit_clk_idx = sa == `PORT_CLK_INDEX;
    assign hit_clk_dat = sa == `PORT_CLK_DATA;
    assign hit_kbc     = sa == `PORT_KBC_DATA || sa == `PORT_KBC_CMD;
    assign hit_mc      = sa == `PORT_MC_DATA || sa == `PORT_MC_CMD;
    assign pcs_act     = (~pcs_s2_q[0] & decode_en_in[`EN_PCS0_BIT])
                       | (~pcs_s2_q[1] & decode_en_in[`EN_PCS1_BIT]);

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cpu_init_out <= 1'b0;
        end else begin
            cpu_init_out <= ~kbc_cpu_reset_req_n_n;
        end
    end

    // Strobe length counter
    logic [`ALE_CNT_W-1:0] ale_cnt_q;
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ale_cnt_q <= '0;
        end else if (iow_fall && hit_clk_idx) begin
            ale_cnt_q <= `ALE_CNT_W'(`ALE_PERIODS);
        end else if (ale_cnt_q != '0) begin
            ale_cnt_q <= ale_cnt_q - 1'b1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            clock_addr_latch_strobe_out <= 1'b0;
        end else if (gpo_sel_in.use_gpo_ale) begin
            clock_addr_latch_strobe_out <= gpo_lvl_in.ale;
        end else begin
            clock_addr_latch_strobe_out <= (iow_fall && hit_clk_idx) || ale_cnt_q > `ALE_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            clock_chip_sel_n_out      <= 1'b1;
            keyboard_ctrl_sel_n_out   <= 1'b1;
            microcontroller_sel_n_out <= 1'b1;
        end else begin
            clock_chip_sel_n_out      <= gpo_sel_in.use_gpo_ccs ? gpo_lvl_in.ccs
                                       : ~(io_cyc & hit_clk_dat);
            keyboard_ctrl_sel_n_out   <= ~(io_cyc & hit_kbc);
            microcontroller_sel_n_out <= ~(io_cyc & hit_mc);
        end
    end

    // Direction control
    dir_state_e dir_q;
    logic       mem_ok;
    assign mem_ok = isa_mst ? fw_dec : (fw_dec | apic_dec);
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            dir_q <= DIR_IDLE;
        end else begin
            case (dir_q)
                DIR_IDLE: begin
                    if (ior_fall) begin
                        dir_q <= DIR_IO;
                    end else if (memr_fall && mem_ok) begin
                        dir_q <= DIR_MEM;
                    end else if (dack_fall) begin
                        dir_q <= DIR_DMA;
                    end
                end
                DIR_IO:  if (cmd_n.ior_n) dir_q <= DIR_IDLE;
                DIR_MEM: if (cmd_n.memr_n) dir_q <= DIR_IDLE;
                DIR_DMA: if (dack_n) dir_q <= DIR_IDLE;
                default: dir_q <= DIR_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            xcvr_direction_n_out <= 1'b1;
        end else if (gpo_sel_in.use_gpo_dir) begin
            xcvr_direction_n_out <= gpo_lvl_in.dir;
        end else begin
            xcvr_direction_n_out <= ~((dir_q != DIR_IDLE) | (pcs_act & ~cmd_n.ior_n));
        end
    end

    // Output enable control
    logic dev_hit;
    logic addr_sel;
    logic oe_q;
    logic any_fall;
    logic any_cmd;
    assign dev_hit = (io_cyc & hit_kbc & decode_en_in[`EN_KBC_BIT])
                   | (io_cyc & (hit_clk_idx | hit_clk_dat) & decode_en_in[`EN_CLK_BIT])
                   | (io_cyc & hit_mc & decode_en_in[`EN_MC_BIT])
                   | (fw_dec & (~cmd_n.memr_n | ~cmd_n.memw_n) & decode_en_in[`EN_FW_BIT])
                   | pcs_act;
    // Enabled address decode, ends ISA master cycles when it stops hitting
    assign addr_sel = (hit_kbc & decode_en_in[`EN_KBC_BIT])
                    | ((hit_clk_idx | hit_clk_dat) & decode_en_in[`EN_CLK_BIT])
                    | (hit_mc & decode_en_in[`EN_MC_BIT])
                    | (fw_dec & decode_en_in[`EN_FW_BIT])
                    | pcs_act;
    assign any_fall = iow_fall | ior_fall | memr_fall | memw_fall;
    assign any_cmd  = ~(&cmd_n);
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            oe_q <= 1'b0;
        end else if (!oe_q) begin
            oe_q <= any_fall & dev_hit;
        end else if (isa_mst) begin
            oe_q <= any_cmd & addr_sel;
        end else begin
            oe_q <= any_cmd;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            xcvr_output_enable_n_out <= 1'b1;
        end else if (gpo_sel_in.use_gpo_oe) begin
            xcvr_output_enable_n_out <= gpo_lvl_in.oe;
        end else begin
            xcvr_output_enable_n_out <= ~oe_q;
        end
    end

    property p_ale_two;
        @(posedge clk_in) disable iff (!rst_b_in)
        (iow_fall && hit_clk_idx && !gpo_sel_in.use_gpo_ale)
        |=> clock_addr_latch_strobe_out [*2] ##1 !clock_addr_latch_strobe_out;
    endproperty
    a_ale_two: assert property (p_ale_two)
        else $error("latch strobe not two periods");
    property p_ale_cause;
        @(posedge clk_in) disable iff (!rst_b_in)
        ($rose(clock_addr_latch_strobe_out) && !gpo_sel_in.use_gpo_ale) |-> $past(iow_fall && hit_clk_idx);
    endproperty
    a_ale_cause: assert property (p_ale_cause)
        else $error("latch strobe without index write");
    property p_dir_io;
        @(posedge clk_in) disable iff (!rst_b_in)
        (dir_q == DIR_IDLE && ior_fall && !gpo_sel_in.use_gpo_dir) |=> ##1 !xcvr_direction_n_out;
    endproperty
    a_dir_io: assert property (p_dir_io)
        else $error("direction not low on io read");
    property p_dir_rel;
        @(posedge clk_in) disable iff (!rst_b_in)
        (dir_q == DIR_IO && cmd_n.ior_n && !pcs_act && !gpo_sel_in.use_gpo_dir) |=> ##1 xcvr_direction_n_out;
    endproperty
    a_dir_rel: assert property (p_dir_rel)
        else $error("direction not released");
    property p_oe_dis;
        @(posedge clk_in) disable iff (!rst_b_in)
        (!oe_q && !dev_hit && !gpo_sel_in.use_gpo_oe) |=> ##1 xcvr_output_enable_n_out;
    endproperty
    a_oe_dis: assert property (p_oe_dis)
        else $error("enable raised for disabled space");
    property p_init;
        @(posedge clk_in) disable iff (!rst_b_in)
        $fell(kbc_cpu_reset_req_n_n) |=> cpu_init_out;
    endproperty
    a_init: assert property (p_init)
        else $error("init not raised");
    property p_ccs;
        @(posedge clk_in) disable iff (!rst_b_in)
        (io_cyc && hit_clk_dat && !gpo_sel_in.use_gpo_ccs) |=> !clock_chip_sel_n_out;
    endproperty
    a_ccs: assert property (p_ccs)
        else $error("clock select missing");
    property p_kbc;
        @(posedge clk_in) disable iff (!rst_b_in)
        (io_cyc && hit_kbc) |=> !keyboard_ctrl_sel_n_out;
    endproperty
    a_kbc: assert property (p_kbc)
        else $error("keyboard select missing");
    property p_mc;
        @(posedge clk_in) disable iff (!rst_b_in)
        (io_cyc && hit_mc) |=> !microcontroller_sel_n_out;
    endproperty
    a_mc: assert property (p_mc)
        else $error("microcontroller select missing");
endmodule
`default_nettype wire

// >>> isa_master_model.sv
// Purpose: ISA bus master that drives command and address pins
// Assumes: Requests change at the falling clock edge
// Notes:   A released address shows its inverse so a stale value never decodes
`default_nettype none
module isa_master_model
    import xbus_pkg::*;
(
    // Bus side
    input  wire logic        clk_in,
    output var  isa_cmd_s    cmd_n_out,
    output var  logic [15:0] sa_out,
    output var  logic        isa_master_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_n_out = 4'hf;
        sa_out = 16'h0000;
        isa_master_out = 1'b0;
    end
    task automatic start(input isa_cmd_s cmd, input logic [15:0] addr, input logic mst);
        @(negedge clk_in);
        sa_out = addr;
        isa_master_out = mst;
        cmd_n_out = cmd;
    endtask
    task automatic move(input logic [15:0] addr);
        @(negedge clk_in);
        sa_out = addr;
    endtask
    task automatic stop();
        @(negedge clk_in);
        cmd_n_out = 4'hf;
        sa_out = ~sa_out;
    endtask
endmodule
`default_nettype wire

// >>> xbus_decode_buffer_control_bench.sv
// Purpose: Self-checking bench for the peripheral bus decode block
// Assumes: 50 MHz clock, synchronous active-low reset
// Notes:   Outputs are sampled well after the input sync chain settles
`default_nettype none
module xbus_decode_buffer_control_bench import xbus_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam isa_cmd_s IOR = 4'h7;
    localparam isa_cmd_s IOW = 4'hb;
    localparam isa_cmd_s MEMR = 4'hd;
    localparam isa_cmd_s MEMW = 4'he;
    typedef struct packed {
        isa_cmd_s    c;
        logic [15:0] a;
        logic [2:0]  mfa;
        logic [4:0]  e;
        logic        oc;
        logic [1:0]  n;
    } row_s;
    localparam row_s ROWS [16] = '{
        {IOW, 16'h0070, 3'h0, 5'h1e, 1'b1, 2'h2}, {IOW, 16'h0070, 3'h4, 5'h1e, 1'b1, 2'h2},
        {IOR, 16'h0071, 3'h0, 5'h0c, 1'b1, 2'h0}, {IOW, 16'h0071, 3'h0, 5'h0e, 1'b1, 2'h0},
        {IOR, 16'h0060, 3'h0, 5'h14, 1'b1, 2'h0}, {IOW, 16'h0064, 3'h0, 5'h16, 1'b1, 2'h0},
        {IOR, 16'h0062, 3'h0, 5'h18, 1'b1, 2'h0}, {IOW, 16'h0066, 3'h0, 5'h1a, 1'b1, 2'h0},
        {IOR, 16'h0300, 3'h0, 5'h1d, 1'b1, 2'h0}, {MEMR, 16'h0000, 3'h2, 5'h1c, 1'b1, 2'h0},
        {MEMR, 16'h0000, 3'h1, 5'h1c, 1'b0, 2'h0}, {MEMR, 16'h0000, 3'h5, 5'h1e, 1'b0, 2'h0},
        {MEMR, 16'h0000, 3'h6, 5'h1c, 1'b1, 2'h0}, {MEMR, 16'h0000, 3'h0, 5'h1f, 1'b1, 2'h0},
        {MEMW, 16'h0000, 3'h2, 5'h1e, 1'b1, 2'h0}, {IOR, 16'h0071, 3'h4, 5'h0c, 1'b1, 2'h0}};
    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    isa_cmd_s    cmd_n;
    logic [15:0] sa;
    logic        mst;
    logic        dma_n = 1'b1;
    logic        req_n = 1'b1;
    logic        fw = 1'b0;
    logic        ap = 1'b0;
    logic        ps0_n = 1'b1;
    logic        ps1_n = 1'b1;
    logic [5:0]  en = 6'h3f;
    gpo_sel_s    gsel = 4'h0;
    gpo_lvl_s    glvl = 4'h0;
    logic        init;
    logic        ale;
    logic        ccs_n;
    logic        kbc_n;
    logic        mc_n;
    logic        dir_n;
    logic        oe_n;
    wire  [4:0]  outs = {ccs_n, kbc_n, mc_n, dir_n, oe_n};
    int          ale_cnt = 0;
    int          bad_count = 0;
    int          num_checks = 0;
    always #10 clk_in = ~clk_in;
    always @(posedge clk_in) if (ale === 1'b1) ale_cnt <= ale_cnt + 1;
    isa_master_model u_isa_master_model (.clk_in(clk_in), .cmd_n_out(cmd_n), .sa_out(sa), .isa_master_out(mst));
    xbus_ctrl u_xbus_ctrl (.clk_in(clk_in), .rst_b_in(rst_b_in), .cmd_n_in(cmd_n), .sa_in(sa),
        .isa_master_in(mst), .dma_read_ack_n_in(dma_n), .kbc_cpu_reset_req_n_in(req_n),
        .fw_decode_in(fw), .apic_decode_in(ap), .prog_sel0_n_in(ps0_n), .prog_sel1_n_in(ps1_n),
        .decode_en_in(en), .gpo_sel_in(gsel), .gpo_lvl_in(glvl), .cpu_init_out(init),
        .clock_addr_latch_strobe_out(ale), .clock_chip_sel_n_out(ccs_n), .keyboard_ctrl_sel_n_out(kbc_n),
        .microcontroller_sel_n_out(mc_n), .xcvr_direction_n_out(dir_n), .xcvr_output_enable_n_out(oe_n));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic probe(input isa_cmd_s c, input logic [15:0] a, input logic m);
        u_isa_master_model.start(c, a, m);
        wt(6);
    endtask
    task automatic done();
        u_isa_master_model.stop();
        wt(8);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        int c0;
        row_s r;
        wt(10);
        chk({3'h0, outs}, 8'h1f);
        chk({7'h0, ale}, 8'h00);
        wt(6);
        @(negedge clk_in) rst_b_in = 1'b1;
        wt(4);
        chk({7'h0, ale}, 8'h00);
        for (int i = 0; i < 16; i++) begin
            r = ROWS[i];
            @(negedge clk_in) {fw, ap} = r.mfa[1:0];
            c0 = ale_cnt;
            probe(r.c, r.a, r.mfa[2]);
            chk({3'h0, outs[4:1], r.oc ? outs[0] : r.e[0]}, {3'h0, r.e});
            done();
            chk({3'h0, outs}, 8'h1f);
            chk(8'(ale_cnt - c0), {6'h0, r.n});
        end
        @(negedge clk_in) {fw, ap} = 2'h0;
        // Address leaving ends an ISA master cycle while the command is still low
        probe(IOR, 16'h0060, 1'b1);
        chk({7'h0, oe_n}, 8'h00);
        u_isa_master_model.move(16'h0300);
        wt(6);
        chk({7'h0, oe_n}, 8'h01);
        done();
        @(negedge clk_in) en = 6'h1b;
        probe(IOR, 16'h0071, 1'b0);
        chk({7'h0, oe_n}, 8'h01);
        done();
        @(negedge clk_in);
        en = 6'h1f;
        ps0_n = 1'b0;
        probe(IOW, 16'h0300, 1'b0);
        chk({7'h0, oe_n}, 8'h00);
        done();
        @(negedge clk_in) {ps0_n, ps1_n} = 2'h2;
        probe(IOW, 16'h0300, 1'b0);
        chk({7'h0, oe_n}, 8'h01);
        done();
        @(negedge clk_in) ps1_n = 1'b1;
        @(negedge clk_in) req_n = 1'b0;
        wt(5);
        chk({7'h0, init}, 8'h01);
        @(negedge clk_in) req_n = 1'b1;
        wt(5);
        chk({7'h0, init}, 8'h00);
        @(negedge clk_in) dma_n = 1'b0;
        wt(6);
        chk({7'h0, dir_n}, 8'h00);
        @(negedge clk_in) dma_n = 1'b1;
        wt(6);
        chk({7'h0, dir_n}, 8'h01);
        for (int k = 0; k < 2; k++) begin
            @(negedge clk_in);
            gsel = 4'hf;
            glvl = k[0] ? 4'ha : 4'h5;
            wt(4);
            chk({4'h0, ale, ccs_n, dir_n, oe_n}, {4'h0, glvl});
        end
        // Reset in mid-cycle, then a first request right after release
        @(negedge clk_in) gsel = 4'h0;
        u_isa_master_model.start(IOR, 16'h0060, 1'b0);
        wt(6);
        chk({3'h0, outs}, 8'h14);
        @(negedge clk_in) rst_b_in = 1'b0;
        wt(2);
        chk({3'h0, outs}, 8'h1f);
        chk({7'h0, ale}, 8'h00);
        u_isa_master_model.stop();
        wt(4);
        @(negedge clk_in) rst_b_in = 1'b1;
        c0 = ale_cnt;
        probe(IOW, 16'h0070, 1'b0);
        chk({3'h0, outs}, 8'h1e);
        done();
        chk({3'h0, outs}, 8'h1f);
        chk(8'(ale_cnt - c0), 8'h02);
        give_verdict();
    end
endmodule
`default_nettype wire
